// [hw/supply_monitor_regs.svh]
`ifndef SUPPLY_MONITOR_REGS_SVH
`define SUPPLY_MONITOR_REGS_SVH
// register byte offsets
`define OFS_STATUS 4'h0
`define OFS_CONFIG 4'h4
`define OFS_IRQ_STATUS 4'h8
`define OFS_IRQ_MASK 4'hC
// status register fields
`define STAT_BELOW_TRIP 0
`define STAT_RESET_ACTIVE 1
`define STAT_HIGH_RANGE 2
`define STAT_RANGE_LOCKED 3
// config register fields
`define CFG_POWER_DOWN 0
`define CFG_RESET_DISABLE 1
`define CFG_RUN_IN_STOP 2
`define CFG_HIGH_RANGE 3
// event bits
`define EVT_FALL 0
`define EVT_RISE 1
`define EVT_RESET 2
`define EVT_WIDTH 3
// reset values
`define CFG_RESET_VALUE 4'h0
`define MASK_RESET_VALUE 3'h0
`endif

// [hw/supply_monitor_pkg.sv]
package supply_monitor_pkg;
  // power mode of the surrounding system
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_WAIT = 2'b01,
    MODE_STOP = 2'b10
  } power_mode_t;
endpackage : supply_monitor_pkg

// [hw/level_sync.sv]
// two-stage synchroniser for asynchronous levels
module level_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_r; // first stage, read only by second stage

  // refuse a width the flops cannot hold, at elaboration
  if (WIDTH < 1) begin : g_width_check
    $error("level_sync width must be positive");
  end

  // two flops, nothing taps the first
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= '0;
      dout <= '0;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule : level_sync

// [hw/avmm_slave.sv]
// avalon-mm slave front end: one cycle waitrequest, then answer
module avmm_slave (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic wr_stb,
  output logic [3:0] wr_addr,
  output logic [7:0] wr_data,
  output logic [3:0] rd_addr,
  input wire logic [7:0] rd_data
);
  logic ack_r; // high in the answer cycle

  // hold waitrequest for one cycle so read data can come from a flop
  assign waitrequest = (read | write) & ~ack_r;
  assign rd_addr = address;
  // only the low byte lane holds bits
  assign wr_stb = write & ack_r & byteenable[0];
  assign wr_addr = address;
  assign wr_data = writedata[7:0];

  // answer phase toggle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (read | write) & ~ack_r;
    end
  end

  // read data captured while waitrequest high, stands at the ack edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      readdata <= 32'h00000000;
    end else if (read & ~ack_r) begin
      readdata <= {24'h000000, rd_data};
    end
  end
endmodule : avmm_slave

// [hw/low_supply_monitor_control.sv]
// Functional notes
// [RL1] flag sets below falling, clears above rising
// [RL2] power-on reset selects the low range
// [RL3] hold reset until supply above rising
// [RL4] monitor enabled out of reset
// [RL5] power-down stops status and reset
// [RL6] reset-disable blocks reset, flag still tracks
// [RL7] range-select picks the high falling threshold
// [RL8] both settings clear: low supply resets
// [RL9] polling software: power-up, reset disabled
// [RL10] range select is write-once until reset
// [RL11] high range below rising: immediate reset
// [RL12] no supply interrupt; flag and reset only
// [RL13] wait mode keeps enabled monitor active
// [RL14] stop mode active only with run-in-stop
// [RL15] comparator outputs synchronised before use
//
// The register offsets and the Avalon-MM register port are this design's own decisions.
`include "supply_monitor_regs.svh"
module low_supply_monitor_control
  import supply_monitor_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  // avalon-mm register port
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // analog comparators, per range, asynchronous
  input wire logic low_below_falling,
  input wire logic low_above_rising,
  input wire logic high_below_falling,
  input wire logic high_above_rising,
  // system power mode
  input wire logic [1:0] power_mode,
  // range select to the analog trip network
  output logic high_range_select,
  // analog bias enable
  output logic monitor_enable,
  // reset request to the system reset logic
  output logic supply_reset_req,
  // block interrupt, from sticky status bits of this wrapper
  output logic irq
);
  logic [3:0] comp_sync; // synchronised comparators
  logic below_falling; // selected range, below falling
  logic above_rising; // selected range, above rising
  logic below_trip_flag_r; // hysteretic status
  logic reset_hold_r; // monitor reset latch
  logic monitor_power_down_r;
  logic monitor_reset_disable_r;
  logic run_in_stop_r;
  logic high_range_select_r;
  logic range_locked_r; // write-once guard
  logic active; // monitor evaluating this cycle
  logic [`EVT_WIDTH-1:0] evt_status_r;
  logic [`EVT_WIDTH-1:0] evt_mask_r;
  logic [`EVT_WIDTH-1:0] evt_set;
  logic flag_prev_r;
  logic reset_prev_r;
  logic range_prev_r; // range select one cycle back
  logic wr_stb;
  logic [3:0] wr_addr;
  logic [7:0] wr_data;
  logic [3:0] rd_addr;
  logic [7:0] rd_data;

  // write decode shared by every writable register
  function automatic logic wr_hit(input logic stb, input logic [3:0] addr, input logic [3:0] ofs);
    return stb && addr == ofs;
  endfunction : wr_hit

  // bus front end
  avmm_slave bus (
    .clk(clk),
    .rstn(rstn),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .byteenable(byteenable),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // comparators cross into clk before any use, see [RL15]
  level_sync #(.WIDTH(4)) comp_sync_u (
    .clk(clk),
    .rstn(rstn),
    .din({high_above_rising, high_below_falling, low_above_rising, low_below_falling}),
    .dout(comp_sync)
  );

  // pick the trip pair of the chosen range, see [RL7]
  assign below_falling = high_range_select_r ? comp_sync[2] : comp_sync[0];
  assign above_rising = high_range_select_r ? comp_sync[3] : comp_sync[1];

  // active unless powered down; in stop needs run-in-stop, see [RL5] see [RL13] see [RL14]
  always_comb begin
    case (power_mode_t'(power_mode))
      MODE_RUN: active = ~monitor_power_down_r;
      MODE_WAIT: active = ~monitor_power_down_r;
      MODE_STOP: active = ~monitor_power_down_r & run_in_stop_r;
      default: active = ~monitor_power_down_r;
    endcase
  end

  assign monitor_enable = active; // see [RL4]
  assign high_range_select = high_range_select_r;

  // configuration; power-up defaults leave the monitor on, low range, see [RL2] see [RL4]
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      monitor_power_down_r <= 1'b0;
      monitor_reset_disable_r <= 1'b0;
      run_in_stop_r <= 1'b0;
    end else if (wr_hit(wr_stb, wr_addr, `OFS_CONFIG)) begin
      monitor_power_down_r <= wr_data[`CFG_POWER_DOWN];
      monitor_reset_disable_r <= wr_data[`CFG_RESET_DISABLE];
      run_in_stop_r <= wr_data[`CFG_RUN_IN_STOP];
    end
  end

  // range select locks at the first config write, see [RL10]
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      high_range_select_r <= 1'b0; // see [RL2]
      range_locked_r <= 1'b0;
    end else if (wr_hit(wr_stb, wr_addr, `OFS_CONFIG) && !range_locked_r) begin
      high_range_select_r <= wr_data[`CFG_HIGH_RANGE];
      range_locked_r <= 1'b1;
    end
  end

  // hysteretic flag: set below falling, clear above rising, else hold, see [RL1]
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      below_trip_flag_r <= 1'b0;
    end else if (active) begin
      if (below_falling) begin
        below_trip_flag_r <= 1'b1;
      end else if (above_rising) begin
        below_trip_flag_r <= 1'b0;
      end
    end
  end

  // reset latch: trips below falling, holds until above rising, see [RL3] see [RL8]
  // switching to the high range while under its rising level trips at once, see [RL11]
  // only the switch itself trips it: a later drift into the band must not reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reset_hold_r <= 1'b0;
    end else if (!active || monitor_reset_disable_r) begin
      reset_hold_r <= 1'b0; // see [RL5] see [RL6]
    end else if (below_falling || (high_range_select_r && !range_prev_r && !above_rising)) begin
      reset_hold_r <= 1'b1;
    end else if (above_rising) begin
      reset_hold_r <= 1'b0;
    end
  end

  // the reset ends wait or stop in the system reset logic, see [RL13] see [RL14]
  assign supply_reset_req = reset_hold_r;

  // edge history for events
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flag_prev_r <= 1'b0;
      reset_prev_r <= 1'b0;
      range_prev_r <= 1'b0;
    end else begin
      flag_prev_r <= below_trip_flag_r;
      reset_prev_r <= reset_hold_r;
      range_prev_r <= high_range_select_r;
    end
  end

  assign evt_set = {reset_hold_r & ~reset_prev_r, ~below_trip_flag_r & flag_prev_r, below_trip_flag_r & ~flag_prev_r};

  // sticky events, write one to clear; a new set beats the clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      evt_status_r <= '0;
    end else begin
      if (wr_hit(wr_stb, wr_addr, `OFS_IRQ_STATUS)) begin
        evt_status_r <= (evt_status_r & ~wr_data[`EVT_WIDTH-1:0]) | evt_set;
      end else begin
        evt_status_r <= evt_status_r | evt_set;
      end
    end
  end

  // interrupt mask
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      evt_mask_r <= `MASK_RESET_VALUE;
    end else if (wr_hit(wr_stb, wr_addr, `OFS_IRQ_MASK)) begin
      evt_mask_r <= wr_data[`EVT_WIDTH-1:0];
    end
  end

  // wrapper interrupt only; the monitor core itself raises none, see [RL12]
  assign irq = |(evt_status_r & evt_mask_r);

  // read mux; unmapped offsets read zero
  always_comb begin
    case (rd_addr)
      `OFS_STATUS: rd_data = {4'h0, range_locked_r, high_range_select_r, reset_hold_r, below_trip_flag_r};
      `OFS_CONFIG: rd_data = {4'h0, high_range_select_r, run_in_stop_r, monitor_reset_disable_r, monitor_power_down_r};
      `OFS_IRQ_STATUS: rd_data = {5'h00, evt_status_r};
      `OFS_IRQ_MASK: rd_data = {5'h00, evt_mask_r};
      default: rd_data = 8'h00;
    endcase
  end
endmodule : low_supply_monitor_control

// [verif/supply_comparator_model.sv]
// behavioural trip network: one comparator pair per range
module supply_comparator_model #(
  parameter logic [7:0] LF = 8'h40,
  parameter logic [7:0] LR = 8'h48,
  parameter logic [7:0] HF = 8'h80,
  parameter logic [7:0] HR = 8'h88
) (
  input wire logic [7:0] level,
  output logic low_below_falling,
  output logic low_above_rising,
  output logic high_below_falling,
  output logic high_above_rising
);
  timeunit 1ns;
  timeprecision 100ps;
  // band between fall and rise leaves both low, so hysteresis is real
  assign low_below_falling = level < LF;
  assign low_above_rising = level > LR;
  assign high_below_falling = level < HF;
  assign high_above_rising = level > HR;
endmodule : supply_comparator_model

// [verif/supply_checker_monitor.sv]
`include "supply_monitor_regs.svh"
module supply_checker
  import supply_monitor_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic waitrequest,
  input wire logic low_below_falling,
  input wire logic low_above_rising,
  input wire logic high_below_falling,
  input wire logic high_above_rising,
  input wire logic [1:0] power_mode,
  input wire logic high_range_select,
  input wire logic monitor_enable,
  input wire logic supply_reset_req
);
  timeunit 1ns;
  timeprecision 100ps;
  // config shadow, snooped off the bus since the checker sees ports only
  logic [3:0] cfg_r;
  // lands at the same edge as the design's own write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_r <= `CFG_RESET_VALUE;
    end else if (write && !waitrequest && address == `OFS_CONFIG && byteenable[0]) begin
      cfg_r <= writedata[3:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_wait_first: assert property ($rose(read || write) |-> waitrequest)
    else $error("no wait cycle on new request");
  a_range_keep: assert property ($past(high_range_select) |-> high_range_select)
    else $error("range select dropped");
  a_range_cause: assert property ($rose(high_range_select)
    |-> $past(write) && $past(address) == `OFS_CONFIG)
    else $error("range select rose without write");
  a_enable_cause: assert property ($changed(monitor_enable) |-> $past(write) || $changed(power_mode))
    else $error("enable moved on its own");
  a_rstdis_quiet: assert property (cfg_r[1] && $past(cfg_r[1]) |-> !supply_reset_req)
    else $error("reset while reset disabled");
  a_inactive_off: assert property (!monitor_enable && !$past(monitor_enable)
    |-> !supply_reset_req)
    else $error("reset from inactive monitor");
  a_low_resets: assert property ((cfg_r[1:0] == 2'h0 && monitor_enable && !high_range_select
    && low_below_falling) [*4] |-> supply_reset_req)
    else $error("low supply gave no reset");
  a_reset_hold: assert property ($fell(supply_reset_req)
    |-> $past(low_above_rising, 3) || !monitor_enable
    || !$past(monitor_enable) || $past(write) || $past(write, 2))
    else $error("reset released below rising");
  a_reset_cause: assert property ($rose(supply_reset_req)
    |-> $past(low_below_falling, 3) || high_range_select
    || $past(write) || $past(write, 2))
    else $error("reset without cause");
  c_reset: cover property ($rose(supply_reset_req));
  c_high: cover property ($rose(high_range_select));
  c_stop_on: cover property (power_mode == MODE_STOP && monitor_enable);
endmodule : supply_checker

// [verif/low_supply_monitor_control_test.sv]
`include "supply_monitor_regs.svh"
module low_supply_monitor_control_test
  import supply_monitor_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] LF = 8'h40, LR = 8'h48, HF = 8'h80, HR = 8'h88;
  logic clk = 0, rstn = 0, read = 0, write = 0, ef, waitrequest, irq;
  logic [3:0] address = 0, byteenable = 4'hF;
  logic [31:0] writedata = 0, readdata, q, seed = 32'h00008CC4;
  logic [1:0] power_mode = MODE_RUN;
  logic [7:0] lvl = 8'h60, l;
  logic [7:0] tbl [3] = '{8'h3F, 8'h48, 8'h49};
  logic low_below_falling, low_above_rising, high_below_falling, high_above_rising;
  logic high_range_select, monitor_enable, supply_reset_req;
  int fail_count = 0, n_checks = 0, k;
  // supply comparators stand in for the analog side
  supply_comparator_model #(.LF(LF), .LR(LR), .HF(HF), .HR(HR)) cmp (.level(lvl), .low_below_falling,
    .low_above_rising, .high_below_falling, .high_above_rising);
  low_supply_monitor_control dut (.clk, .rstn, .address, .read, .write, .writedata, .byteenable, .readdata,
    .waitrequest, .low_below_falling, .low_above_rising, .high_below_falling, .high_above_rising, .power_mode,
    .high_range_select, .monitor_enable, .supply_reset_req, .irq);
  initial forever #2.5 clk = ~clk;
  // xorshift source, fixed seed keeps runs repeatable
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // next flag value: hold inside the hysteresis band
  function automatic logic nf(input logic f, input logic [7:0] v);
    return v < LF ? 1'b1 : (v > LR ? 1'b0 : f);
  endfunction : nf
  task automatic report_and_stop(input bit to);
    if (to) fail_count++;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one avalon transfer, held until waitrequest samples low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int i;
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= {24'h0, d};
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (i == 20) report_and_stop(1);
    @(posedge clk);
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    check(q, e);
  endtask : rd
  // new supply level, then wait out sync and update latency
  task automatic lv(input logic [7:0] v);
    @(posedge clk);
    lvl <= v;
    repeat (5) @(posedge clk);
  endtask : lv
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check(high_range_select, 1'b0);
    check(monitor_enable, 1'b1);
    rd(`OFS_CONFIG, 32'h0);
    rd(4'h2, 32'h0);
    bus(1'b1, `OFS_CONFIG, 8'h02);
    ef = 1'b0;
    for (k = 0; k < 15; k++) begin
      l = k < 3 ? tbl[k] : 8'h30 + 8'(xs() % 48);
      lv(l);
      ef = nf(ef, l);
      rd(`OFS_STATUS, {28'h0, 3'b100, ef});
      check(supply_reset_req, 1'b0);
    end
    lv(8'h60);
    bus(1'b1, `OFS_IRQ_STATUS, 8'h07);
    rd(`OFS_IRQ_STATUS, 32'h0);
    check(irq, 1'b0);
    bus(1'b1, `OFS_IRQ_MASK, 8'h01);
    lv(8'h30);
    check(irq, 1'b1);
    bus(1'b1, `OFS_IRQ_MASK, 8'h00);
    check(irq, 1'b0);
    // low byte lane off: the mask write must not land
    byteenable <= 4'hE;
    bus(1'b1, `OFS_IRQ_MASK, 8'h01);
    byteenable <= 4'hF;
    check(irq, 1'b0);
    lv(8'h60);
    bus(1'b1, `OFS_IRQ_MASK, 8'h07);
    bus(1'b1, `OFS_IRQ_STATUS, 8'h07);
    check(irq, 1'b0);
    bus(1'b1, `OFS_CONFIG, 8'h03);
    check(monitor_enable, 1'b0);
    lv(8'h30);
    rd(`OFS_STATUS, 32'h8);
    bus(1'b1, `OFS_CONFIG, 8'h00);
    lv(8'h30);
    check(supply_reset_req, 1'b1);
    lv(8'h44);
    check(supply_reset_req, 1'b1);
    lv(8'h50);
    check(supply_reset_req, 1'b0);
    @(posedge clk) power_mode <= MODE_WAIT;
    lv(8'h30);
    check(supply_reset_req & monitor_enable, 1'b1);
    lv(8'h50);
    @(posedge clk) power_mode <= MODE_STOP;
    lv(8'h30);
    check({monitor_enable, supply_reset_req}, 2'b00);
    // the spare mode code behaves as run
    @(posedge clk) power_mode <= 2'b11;
    lv(8'h30);
    check({monitor_enable, supply_reset_req}, 2'b11);
    @(posedge clk) power_mode <= MODE_STOP;
    lv(8'h50);
    bus(1'b1, `OFS_CONFIG, 8'h04);
    lv(8'h30);
    check({monitor_enable, supply_reset_req}, 2'b11);
    lv(8'h50);
    @(posedge clk) power_mode <= MODE_RUN;
    bus(1'b1, `OFS_CONFIG, 8'h08);
    check(high_range_select, 1'b0);
    // second reset in mid-run unlocks the range
    @(posedge clk) rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    // park inside the high band, above the low rising level
    lv(8'h84);
    check({high_range_select, supply_reset_req}, 2'b00);
    bus(1'b1, `OFS_CONFIG, 8'h08);
    check(high_range_select, 1'b1);
    lv(8'h84);
    check(supply_reset_req, 1'b1);
    lv(8'h90);
    check(supply_reset_req, 1'b0);
    // back into the band from above: no reset
    lv(8'h84);
    check(supply_reset_req, 1'b0);
    bus(1'b1, `OFS_CONFIG, 8'h00);
    check(high_range_select, 1'b1);
    lv(8'h70);
    check(supply_reset_req, 1'b1);
    lv(8'h90);
    rd(`OFS_STATUS, 32'hC);
    report_and_stop(0);
  end
endmodule : low_supply_monitor_control_test
bind low_supply_monitor_control supply_checker chk (.clk, .rstn, .address, .read, .write, .writedata,
  .byteenable, .waitrequest, .low_below_falling, .low_above_rising, .high_below_falling, .high_above_rising,
  .power_mode, .high_range_select, .monitor_enable, .supply_reset_req);
